// ==== rtl/hda_widget_verb_handler.sv ====
// Purpose: Verb decoder for root, function group and three output nodes.
// Assumes: frame_i pulses once per response frame on core_clk_i.
// Notes: Verbs to nodes above the surround output are left to others.

`timescale 1ns/1ps
`default_nettype none

module hda_widget_verb_handler
   import hda_verb_pkg::*;
#(
   parameter int PCM_W = 20,
   // Identification value is arbitrary.
   parameter logic [31:0] VENDOR_DEVICE_ID = 32'h1234_5678
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic verb_valid_i,
   input wire logic [31:0] verb_i,
   input wire logic frame_i,
   output logic resp_valid_o,
   output logic [31:0] resp_o,
   input wire logic spdif_source_adc_i,
   input wire logic [PCM_W-1:0] link_pcm_i,
   input wire logic [PCM_W-1:0] adc_pcm_i,
   output logic [PCM_W-1:0] spdif_pcm_o,
   output logic [7:0] proc_state_o,
   output logic equalizer_mute_bit_o,
   output logic coefficient_symmetry_bit_o
);

   // ------------------------------------------------------------
   // Verb fields
   // ------------------------------------------------------------
   logic [7:0] nid;
   logic [11:0] v12;
   logic [3:0] v4;
   logic [7:0] payload8;
   logic [15:0] payload16;
   logic node_hit;
   cmd_t cmd;

   assign nid = verb_i[NID_LSB +: 8];
   assign v12 = verb_i[V12_LSB +: 12];
   assign v4 = verb_i[V4_LSB +: 4];
   assign payload8 = verb_i[7:0];
   assign payload16 = verb_i[15:0];
   // Higher nodes belong to other blocks and get no response here.
   assign node_hit = (nid <= NID_SURR);

   // ------------------------------------------------------------
   // Coefficient and state storage
   // ------------------------------------------------------------
   logic afg_sel;
   logic front_sel;
   logic [7:0] afg_index;
   logic [15:0] afg_data;
   logic [7:0] front_index;
   logic [15:0] front_data;
   logic front_sym;

   // Only the function group and the front output hold coefficients;
   // the function group never mirrors a write into the other channel.
   assign afg_sel = (nid == NID_AFG);
   assign front_sel = (nid == NID_FRONT);

   hda_coef_store #(
      .IDX_W(8),
      .DATA_W(16)
   ) u_afg_store (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .idx_we_i(cmd == CMD_SET_IDX && afg_sel),
      .idx_i(payload8),
      .data_we_i(cmd == CMD_SET_COEF && afg_sel),
      .data_i(payload16),
      .sym_i(1'b0),
      .index_o(afg_index),
      .data_o(afg_data)
   );

   hda_coef_store #(
      .IDX_W(8),
      .DATA_W(16)
   ) u_front_store (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .idx_we_i(cmd == CMD_SET_IDX && front_sel),
      .idx_i(payload8),
      .data_we_i(cmd == CMD_SET_COEF && front_sel),
      .data_i(payload16),
      .sym_i(front_sym),
      .index_o(front_index),
      .data_o(front_data)
   );

   hda_proc_state u_proc_state (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .we_i(cmd == CMD_SET_PSTATE),
      .state_i(payload8),
      .state_o(proc_state_o),
      .equalizer_mute_bit_o(equalizer_mute_bit_o),
      .coefficient_symmetry_bit_o(front_sym)
   );

   assign coefficient_symmetry_bit_o = front_sym;

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   // Unknown verbs to served nodes still answer with zero so the
   // controller never waits on a missing response.
   always_comb begin
      cmd = CMD_NONE;
      if (verb_valid_i && node_hit) begin
         cmd = CMD_ZERO;
         if (v12 == VERB_GET_PARAM) begin
            cmd = CMD_PARAM;
         end else if (v12 == VERB_GET_SDI || v12 == VERB_SET_SDI) begin
            cmd = CMD_ZERO;
         end else if (v12 == VERB_GET_PSTATE) begin
            if (front_sel) begin
               cmd = CMD_GET_PSTATE;
            end else begin
               cmd = CMD_ZERO;
            end
         end else if (v12 == VERB_SET_PSTATE) begin
            if (front_sel) begin
               cmd = CMD_SET_PSTATE;
            end else begin
               cmd = CMD_ZERO;
            end
         end else if (afg_sel || front_sel) begin
            if (v4 == V4_GET_COEF) begin
               cmd = CMD_GET_COEF;
            end else if (v4 == V4_SET_COEF) begin
               cmd = CMD_SET_COEF;
            end else if (v4 == V4_GET_IDX) begin
               cmd = CMD_GET_IDX;
            end else if (v4 == V4_SET_IDX) begin
               cmd = CMD_SET_IDX;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Parameter answers
   // ------------------------------------------------------------
   logic [31:0] param_word;
   logic [7:0] param_id;

   assign param_id = payload8;

   always_comb begin
      param_word = '0;
      if (nid == NID_ROOT) begin
         if (param_id == PARAM_VENDOR) begin
            param_word = VENDOR_DEVICE_ID;
         end else if (param_id == PARAM_SUBNODES) begin
            param_word = {8'h00, ROOT_FIRST, 8'h00, ROOT_COUNT};
         end
      end else if (afg_sel) begin
         if (param_id == PARAM_FG_TYPE) begin
            param_word = {24'h000000, FG_TYPE_AUDIO};
         end else if (param_id == PARAM_SUBNODES) begin
            param_word = {8'h00, AFG_FIRST, 8'h00, AFG_COUNT};
         end
      end else if (param_id == PARAM_WCAPS) begin
         param_word = 32'(WTYPE_OUTPUT) << WCAPS_TYPE_LSB;
      end
   end

   // ------------------------------------------------------------
   // Response selection
   // ------------------------------------------------------------
   logic [31:0] next_resp;
   logic [7:0] sel_index;
   logic [15:0] sel_data;

   assign sel_index = front_sel ? front_index : afg_index;
   assign sel_data = front_sel ? front_data : afg_data;

   always_comb begin
      next_resp = '0;
      unique case (cmd)
         CMD_PARAM: begin
            next_resp = param_word;
         end
         CMD_GET_COEF: begin
            next_resp = {16'h0000, sel_data};
         end
         CMD_GET_IDX: begin
            next_resp = {24'h000000, sel_index};
         end
         CMD_GET_PSTATE: begin
            next_resp = {24'h000000, proc_state_o};
         end
         CMD_NONE, CMD_ZERO, CMD_SET_COEF, CMD_SET_IDX,
         CMD_SET_PSTATE: begin
            next_resp = '0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Response frame handshake
   // ------------------------------------------------------------
   // A verb taken in the same cycle as a frame pulse waits for the
   // following frame, so the answer never precedes its cause.
   resp_state_t resp_state;
   logic [31:0] held_resp;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         resp_state <= RESP_IDLE;
      end else if (ce_i) begin
         unique case (resp_state)
            RESP_IDLE: begin
               if (cmd != CMD_NONE) begin
                  resp_state <= RESP_PEND;
               end
            end
            RESP_PEND: begin
               if (frame_i && cmd == CMD_NONE) begin
                  resp_state <= RESP_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         held_resp <= '0;
      end else if (ce_i && cmd != CMD_NONE) begin
         held_resp <= next_resp;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         resp_valid_o <= 1'b0;
         resp_o <= '0;
      end else if (ce_i) begin
         resp_valid_o <= frame_i && resp_state == RESP_PEND;
         if (frame_i && resp_state == RESP_PEND) begin
            resp_o <= held_resp;
         end
      end
   end

   // ------------------------------------------------------------
   // Source pin synchroniser
   // ------------------------------------------------------------
   // The source pin comes from outside the clock domain. A new level
   // counts once the second and third stages agree, so a runt pulse
   // on the pin cannot flip the stream source.
   logic [2:0] src_sync;
   logic src_agree;
   logic adc_selected;

   assign src_agree = (src_sync[1] == src_sync[2]);

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         src_sync <= '0;
      end else if (ce_i) begin
         src_sync <= {src_sync[1:0], spdif_source_adc_i};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         adc_selected <= 1'b0;
      end else if (ce_i && src_agree) begin
         adc_selected <= src_sync[2];
      end
   end

   // ------------------------------------------------------------
   // Digital output source
   // ------------------------------------------------------------
   // The filtered pin level picks the sample, so a change of the pin
   // reaches the stream output four cycles after it is first sampled.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         spdif_pcm_o <= '0;
      end else if (ce_i) begin
         if (adc_selected) begin
            spdif_pcm_o <= adc_pcm_i;
         end else begin
            spdif_pcm_o <= link_pcm_i;
         end
      end
   end

endmodule
`default_nettype wire

// ==== rtl/hda_verb_pkg.sv ====
// Purpose: Constants and types for the widget verb handler.
// Assumes: Verbs arrive as 32-bit words, responses leave as 32-bit words.
// Notes: Node, verb and parameter codes follow the HD audio verb layout.

package hda_verb_pkg;

   // ------------------------------------------------------------
   // Node identifiers
   // ------------------------------------------------------------
   localparam logic [7:0] NID_ROOT = 8'h00;
   localparam logic [7:0] NID_AFG = 8'h01;
   localparam logic [7:0] NID_DIGOUT = 8'h02;
   localparam logic [7:0] NID_FRONT = 8'h03;
   localparam logic [7:0] NID_SURR = 8'h04;

   // ------------------------------------------------------------
   // Verb word layout and verb codes
   // ------------------------------------------------------------
   localparam int NID_LSB = 20;
   localparam int V12_LSB = 8;
   localparam int V4_LSB = 16;
   localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
   localparam logic [11:0] VERB_GET_SDI = 12'hf04;
   localparam logic [11:0] VERB_SET_SDI = 12'h704;
   localparam logic [11:0] VERB_GET_PSTATE = 12'hf03;
   localparam logic [11:0] VERB_SET_PSTATE = 12'h703;
   localparam logic [3:0] V4_GET_COEF = 4'hc;
   localparam logic [3:0] V4_SET_COEF = 4'h4;
   localparam logic [3:0] V4_GET_IDX = 4'hd;
   localparam logic [3:0] V4_SET_IDX = 4'h5;

   // ------------------------------------------------------------
   // Parameter codes and their fields
   // ------------------------------------------------------------
   localparam logic [7:0] PARAM_VENDOR = 8'h00;
   localparam logic [7:0] PARAM_SUBNODES = 8'h04;
   localparam logic [7:0] PARAM_FG_TYPE = 8'h05;
   localparam logic [7:0] PARAM_WCAPS = 8'h09;
   localparam logic [7:0] FG_TYPE_AUDIO = 8'h01;
   localparam logic [3:0] WTYPE_OUTPUT = 4'h0;
   localparam int WCAPS_TYPE_LSB = 20;
   localparam int SUB_START_LSB = 16;
   localparam logic [7:0] ROOT_FIRST = 8'h01;
   localparam logic [7:0] ROOT_COUNT = 8'h01;
   localparam logic [7:0] AFG_FIRST = 8'h02;
   localparam logic [7:0] AFG_COUNT = 8'h03;

   // ------------------------------------------------------------
   // Processing state encoding
   // ------------------------------------------------------------
   localparam logic [7:0] PSTATE_RESET = 8'h00;
   localparam int PSTATE_SYM_OFF_BIT = 7;
   localparam logic [6:0] PSTATE_OFF = 7'h00;
   localparam logic [6:0] PSTATE_BENIGN_A = 7'h01;
   localparam logic [6:0] PSTATE_BENIGN_B = 7'h02;
   localparam int IDX_CHAN_BIT = 6;

   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_ZERO,
      CMD_PARAM,
      CMD_GET_COEF,
      CMD_SET_COEF,
      CMD_GET_IDX,
      CMD_SET_IDX,
      CMD_GET_PSTATE,
      CMD_SET_PSTATE
   } cmd_t;

   typedef enum logic {
      RESP_IDLE,
      RESP_PEND
   } resp_state_t;

endpackage

// ==== rtl/hda_coef_store.sv ====
// Purpose: Index register and coefficient memory for one node.
// Assumes: One access per verb; index and data writes never coincide.
// Notes: With mirroring on, a write lands in both channel halves.

`timescale 1ns/1ps
`default_nettype none

module hda_coef_store
   import hda_verb_pkg::*;
#(
   parameter int IDX_W = 8,
   parameter int DATA_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic idx_we_i,
   input wire logic [IDX_W-1:0] idx_i,
   input wire logic data_we_i,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic sym_i,
   output logic [IDX_W-1:0] index_o,
   output logic [DATA_W-1:0] data_o
);

   localparam logic [IDX_W-1:0] CHAN_MASK = IDX_W'(1) << IDX_CHAN_BIT;

   logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

   // Only an explicit index write moves the index.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         index_o <= '0;
      end else if (ce_i && idx_we_i) begin
         index_o <= idx_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (ce_i && data_we_i) begin
         mem[index_o] <= data_i;
         if (sym_i) begin
            mem[index_o ^ CHAN_MASK] <= data_i;
         end
      end
   end

   assign data_o = mem[index_o];

endmodule
`default_nettype wire

// ==== rtl/hda_proc_state.sv ====
// Purpose: Front output equalizer processing state register.
// Assumes: Written only by the processing state set verb.
// Notes: Any nonzero low part is a benign (enabled) state.

`timescale 1ns/1ps
`default_nettype none

module hda_proc_state
   import hda_verb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [7:0] state_i,
   output logic [7:0] state_o,
   output logic equalizer_mute_bit_o,
   output logic coefficient_symmetry_bit_o
);

   logic [6:0] next_low;

   // Unlisted enabled codes fold onto the first benign code.
   always_comb begin
      if (state_i[6:0] == PSTATE_OFF) begin
         next_low = PSTATE_OFF;
      end else if (state_i[6:0] == PSTATE_BENIGN_B) begin
         next_low = PSTATE_BENIGN_B;
      end else begin
         next_low = PSTATE_BENIGN_A;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         state_o <= PSTATE_RESET;
      end else if (ce_i && we_i) begin
         state_o <= {state_i[PSTATE_SYM_OFF_BIT], next_low};
      end
   end

   // The mute bit is the inverse of the enable state.
   assign equalizer_mute_bit_o = (state_o[6:0] == PSTATE_OFF);
   assign coefficient_symmetry_bit_o = !state_o[PSTATE_SYM_OFF_BIT];

endmodule
`default_nettype wire

// ==== test/hda_verb_chk.sv ====
// Purpose: Port checker for the widget verb handler.
// Assumes: One verb per response frame.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module hda_verb_chk
   import hda_verb_pkg::*;
#(
   parameter int PCM_W = 20
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic verb_valid_i,
   input wire logic [31:0] verb_i,
   input wire logic frame_i,
   input wire logic resp_valid_o,
   input wire logic [31:0] resp_o,
   input wire logic spdif_source_adc_i,
   input wire logic [PCM_W-1:0] link_pcm_i,
   input wire logic [PCM_W-1:0] adc_pcm_i,
   input wire logic [PCM_W-1:0] spdif_pcm_o,
   input wire logic [7:0] proc_state_o,
   input wire logic equalizer_mute_bit_o,
   input wire logic coefficient_symmetry_bit_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic take;
   logic [7:0] exp_state;
   assign take = ce_i && verb_valid_i;
   sequence pstate_set;
      take && verb_i[27:8] == {NID_FRONT, VERB_SET_PSTATE};
   endsequence
   sequence pstate_get;
      take && verb_i[27:8] == {NID_FRONT, VERB_GET_PSTATE};
   endsequence
   sequence sdi_get;
      take && verb_i[19:8] == VERB_GET_SDI && verb_i[27:20] <= NID_SURR;
   endsequence
   // Expected state after a set: benign low parts fold to 1 or 2.
   always_ff @(posedge core_clk_i) begin
      if (take && verb_i[27:8] == {NID_FRONT, VERB_SET_PSTATE}) begin
         exp_state <= {verb_i[7], (verb_i[6:0] == 7'h00) ? 7'h00 :
                       (verb_i[6:0] == 7'h02) ? 7'h02 : 7'h01};
      end
   end
   AST_RESET_VALUES: assert property ($rose(rst_b_i) |->
      proc_state_o == 8'h00 && !resp_valid_o && coefficient_symmetry_bit_o)
      else $error("state not cleared by reset");
   AST_MUTE_FROM_STATE: assert property (
      equalizer_mute_bit_o == (proc_state_o[6:0] == 7'h00))
      else $error("mute bit disagrees with state");
   AST_SYM_FROM_STATE: assert property (
      coefficient_symmetry_bit_o == !proc_state_o[7])
      else $error("symmetry bit disagrees with state");
   AST_STATE_ADOPTED: assert property (
      pstate_set |-> ##[1:2] proc_state_o == exp_state)
      else $error("state set not adopted");
   AST_STATE_READBACK: assert property (pstate_get |->
      ##[1:12] resp_valid_o && resp_o == {24'h0, proc_state_o})
      else $error("state get wrong");
   AST_SDI_ZERO: assert property (
      sdi_get |-> ##[1:12] resp_valid_o && resp_o == 32'h0)
      else $error("input line get not zero");
   AST_RESP_ON_FRAME: assert property (
      resp_valid_o |-> $past(frame_i))
      else $error("response not after frame");
   AST_RESP_PULSE: assert property (
      resp_valid_o |=> !resp_valid_o)
      else $error("response longer than one cycle");
   // The source pin passes a filter, so only a level held with the
   // clock enabled for five cycles is known to pick the sample.
   sequence src_settled;
      (ce_i && spdif_source_adc_i == $past(spdif_source_adc_i)) [*5];
   endsequence
   AST_SPDIF_SOURCE: assert property (src_settled |=> spdif_pcm_o ==
      ($past(spdif_source_adc_i) ? $past(adc_pcm_i) : $past(link_pcm_i)))
      else $error("digital output source wrong");
endmodule
bind hda_widget_verb_handler hda_verb_chk #(.PCM_W(PCM_W)) u_chk (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
   .verb_valid_i(verb_valid_i), .verb_i(verb_i), .frame_i(frame_i),
   .resp_valid_o(resp_valid_o), .resp_o(resp_o),
   .spdif_source_adc_i(spdif_source_adc_i), .link_pcm_i(link_pcm_i),
   .adc_pcm_i(adc_pcm_i), .spdif_pcm_o(spdif_pcm_o),
   .proc_state_o(proc_state_o), .equalizer_mute_bit_o(equalizer_mute_bit_o),
   .coefficient_symmetry_bit_o(coefficient_symmetry_bit_o));
`default_nettype wire

// ==== test/hda_ctrl_model.sv ====
// Purpose: Behavioural link controller issuing verbs.
// Assumes: Frame every eight clocks.
// Notes: Verb lines show an inverted pattern when idle.
`timescale 1ns/1ps
`default_nettype none
module hda_ctrl_model
   import hda_verb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resp_valid_i,
   input wire logic [31:0] resp_i,
   output logic verb_valid_o,
   output logic [31:0] verb_o,
   output logic frame_o
);
   // ------------------------------------------------------------
   // Frames and verb transfers
   // ------------------------------------------------------------
   logic [2:0] fcnt = 3'h0;
   assign frame_o = (fcnt == 3'h7);
   always @(posedge core_clk_i) begin
      fcnt <= fcnt + 3'h1;
   end
   initial begin
      verb_valid_o = 1'b0;
      verb_o = 32'h0;
   end
   task automatic xfer(input logic [31:0] v, output logic [31:0] r);
      r = 'x;
      @(posedge core_clk_i);
      verb_valid_o <= 1'b1;
      verb_o <= v;
      @(posedge core_clk_i);
      verb_valid_o <= 1'b0;
      verb_o <= ~v;
      for (int n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (resp_valid_i === 1'b1) begin
            r = resp_i;
            break;
         end
      end
   endtask
   // The index never advances, so it is reloaded before every access.
   task automatic coef(input logic [7:0] nid, input logic [7:0] idx,
                       input logic wr, input logic [15:0] d,
                       output logic [31:0] r);
      xfer({4'h0, nid, V4_SET_IDX, 8'h00, idx}, r);
      xfer({4'h0, nid, wr ? V4_SET_COEF : V4_GET_COEF, d}, r);
   endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the widget verb handler.
// Assumes: Controller model sends one verb per frame.
// Notes: Expected values come from the verb tables.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import hda_verb_pkg::*;
   // ------------------------------------------------------------
   // Bench
   // ------------------------------------------------------------
   // Identification value is arbitrary.
   localparam logic [31:0] VENDOR_ID = 32'h0bad_cafe;
   localparam logic [7:0] ST_VALS [8] = '{8'h00, 8'h01, 8'h02, 8'h80,
                                          8'h81, 8'h82, 8'h03, 8'h00};
   logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, src_adc = 1'b0;
   logic [19:0] link_pcm = 20'h0, adc_pcm = 20'h0, spdif_pcm;
   logic verb_valid, frame, resp_valid, mute, coefficient_symmetry_bit;
   logic [31:0] verb, resp;
   logic [7:0] pstate;
   int n_fail = 0, total_checks = 0;
   always #2 clk = ~clk;
   hda_widget_verb_handler #(.VENDOR_DEVICE_ID(VENDOR_ID)) DUT (
      .core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
      .verb_valid_i(verb_valid), .verb_i(verb), .frame_i(frame),
      .resp_valid_o(resp_valid), .resp_o(resp),
      .spdif_source_adc_i(src_adc), .link_pcm_i(link_pcm),
      .adc_pcm_i(adc_pcm), .spdif_pcm_o(spdif_pcm), .proc_state_o(pstate),
      .equalizer_mute_bit_o(mute), .coefficient_symmetry_bit_o(coefficient_symmetry_bit));
   hda_ctrl_model u_ctl (.core_clk_i(clk), .resp_valid_i(resp_valid),
      .resp_i(resp), .verb_valid_o(verb_valid), .verb_o(verb),
      .frame_o(frame));
   function automatic logic [31:0] v12(logic [7:0] n, logic [11:0] v,
                                       logic [7:0] p);
      return {4'h0, n, v, p};
   endfunction
   function automatic logic [31:0] v4(logic [7:0] n, logic [3:0] c,
                                      logic [15:0] p);
      return {4'h0, n, c, p};
   endfunction
   function automatic logic [7:0] exp_st(logic [7:0] p);
      return {p[7], (p[6:0] == 7'h0) ? 7'h0 : (p[6:0] == 7'h2) ? 7'h2 : 7'h1};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic t_ident;
      logic [31:0] r;
      u_ctl.xfer(v12(NID_ROOT, VERB_GET_PARAM, PARAM_VENDOR), r);
      check(r, VENDOR_ID);
      u_ctl.xfer(v12(NID_AFG, VERB_GET_PARAM, PARAM_FG_TYPE), r);
      check(r, {24'h0, FG_TYPE_AUDIO});
      u_ctl.xfer(v12(NID_AFG, VERB_GET_PARAM, PARAM_SUBNODES), r);
      check(r, {8'h0, AFG_FIRST, 8'h0, AFG_COUNT});
      u_ctl.xfer(v12(NID_ROOT, VERB_GET_PARAM, PARAM_SUBNODES), r);
      check(r, {8'h0, ROOT_FIRST, 8'h0, ROOT_COUNT});
      for (int n = 2; n <= 4; n++) begin
         u_ctl.xfer(v12(8'(n), VERB_GET_PARAM, PARAM_WCAPS), r);
         check(r, {8'h0, WTYPE_OUTPUT, 20'h0});
      end
   endtask
   task automatic t_sdi;
      logic [31:0] r;
      for (int n = 0; n <= 4; n++) begin
         u_ctl.xfer(v12(8'(n), VERB_SET_SDI, 8'h03), r);
         check(r, 32'h0);
         u_ctl.xfer(v12(8'(n), VERB_GET_SDI, 8'h00), r);
         check(r, 32'h0);
      end
   endtask
   task automatic t_afg;
      logic [31:0] r;
      u_ctl.coef(NID_AFG, 8'h12, 1'b1, 16'hbeef, r);
      u_ctl.coef(NID_AFG, 8'h13, 1'b1, 16'h1234, r);
      u_ctl.xfer(v4(NID_AFG, V4_GET_IDX, 16'h0), r);
      check(r, 32'h13);
      u_ctl.coef(NID_AFG, 8'h12, 1'b0, 16'h0, r);
      check(r, 32'hbeef);
      u_ctl.xfer(v4(NID_AFG, V4_GET_COEF, 16'h0), r);
      check(r, 32'hbeef);
      u_ctl.xfer(v12(NID_AFG, VERB_SET_PSTATE, 8'h81), r);
      u_ctl.xfer(v12(NID_AFG, VERB_GET_PSTATE, 8'h00), r);
      check(r, 32'h0);
      check({24'h0, pstate}, 32'h0);
   endtask
   task automatic t_state;
      logic [31:0] r;
      logic [7:0] e;
      foreach (ST_VALS[i]) begin
         u_ctl.xfer(v12(NID_FRONT, VERB_SET_PSTATE, ST_VALS[i]), r);
         u_ctl.xfer(v12(NID_FRONT, VERB_GET_PSTATE, 8'h00), r);
         e = exp_st(ST_VALS[i]);
         check(r, {24'h0, e});
         check({30'h0, mute, coefficient_symmetry_bit}, {30'h0, e[6:0] == 7'h0, !e[7]});
      end
   endtask
   task automatic t_sym;
      logic [31:0] r;
      u_ctl.xfer(v12(NID_FRONT, VERB_SET_PSTATE, 8'h00), r);
      u_ctl.coef(NID_FRONT, 8'h05, 1'b1, 16'ha5a5, r);
      u_ctl.coef(NID_FRONT, 8'h45, 1'b0, 16'h0, r);
      check(r, 32'ha5a5);
      u_ctl.xfer(v12(NID_FRONT, VERB_SET_PSTATE, 8'h80), r);
      u_ctl.coef(NID_FRONT, 8'h07, 1'b1, 16'h1111, r);
      u_ctl.coef(NID_FRONT, 8'h47, 1'b1, 16'h2222, r);
      u_ctl.coef(NID_FRONT, 8'h07, 1'b0, 16'h0, r);
      check(r, 32'h1111);
   endtask
   task automatic t_spdif;
      @(posedge clk);
      link_pcm <= 20'h12345;
      adc_pcm <= 20'habcde;
      repeat (2) @(posedge clk);
      #1 check({12'h0, spdif_pcm}, 32'h12345);
      @(posedge clk);
      src_adc <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check({12'h0, spdif_pcm}, 32'h12345);
      @(posedge clk);
      #1 check({12'h0, spdif_pcm}, 32'habcde);
      @(posedge clk);
      ce <= 1'b0;
      src_adc <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({12'h0, spdif_pcm}, 32'habcde);
      @(posedge clk);
      ce <= 1'b1;
   endtask
   task automatic t_reset;
      logic [31:0] r;
      u_ctl.xfer(v12(NID_FRONT, VERB_SET_PSTATE, 8'h81), r);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1 check({22'h0, mute, coefficient_symmetry_bit, pstate}, {22'h0, 2'b11, 8'h00});
      u_ctl.xfer(v12(NID_FRONT, VERB_GET_PSTATE, 8'h00), r);
      check(r, {24'h0, PSTATE_RESET});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_ident;
      t_sdi;
      t_afg;
      t_state;
      t_sym;
      t_spdif;
      t_reset;
      complete_run;
   end
   initial begin
      #(4 * 20000);
      n_fail++;
      complete_run;
   end
endmodule
`default_nettype wire
